// ===== dv/slm_link_param_monitor_assertions.sv
`timescale 1ns/10ps
// ==========================================
// Port checks of the register bank
module slm_link_param_monitor_assertions #(
  parameter int LANES = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] err_threshold,
  input wire logic samples_less_one,
  input wire logic [7:0] lane0_check_value,
  input wire logic [7:0] lane_align_mask,
  input wire logic [LANES-1:0] disparity_threshold_flags,
  input wire logic [LANES-1:0] disparity_counter_off
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic dw;
  logic f0;
  // Control write aimed at lane 0
  assign dw = reg_wr_en && reg_addr == 12'h46D && reg_wdata[2:0] == 3'h0;
  assign f0 = disparity_threshold_flags[0];
  AST_CKSUM: assert property (reg_wr_en && reg_addr == 12'h45D
    |=> lane0_check_value == $past(reg_wdata)) else $error("checksum write lost");
  AST_MASK: assert property (reg_wr_en && reg_addr == 12'h46C
    |=> lane_align_mask == $past(reg_wdata)) else $error("deskew mask write lost");
  AST_SAMP: assert property (reg_wr_en && reg_addr == 12'h459
    |=> samples_less_one == $past(reg_wdata[0])) else $error("sample field wrong");
  AST_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved");
  AST_FLAGRD: assert property (reg_rd_en && reg_addr == 12'h46D
    |=> reg_rdata == 8'($past(disparity_threshold_flags))) else $error("flag read wrong");
  AST_NOTHR: assert property (err_threshold == 8'h00 && !f0 |=> !f0)
    else $error("flag set with threshold off");
  AST_STICKY: assert property (f0 && !(dw && (reg_wdata[7] || reg_wdata[5]))
    |=> f0) else $error("flag dropped");
  AST_RSTCNT: assert property (dw && reg_wdata[5] |=> !f0)
    else $error("counter reset kept flag");
  AST_OFF: assert property (dw && reg_wdata[6] |=> disparity_counter_off[0] [*3])
    else $error("counter not disabled");
  cover property (f0);
  cover property (dw && reg_wdata[5]);
  cover property (reg_rd_en && reg_addr == 12'h46B);
endmodule
bind slm_link_param_monitor slm_link_param_monitor_assertions #(.LANES(LANES)) u_chk (
  .mclk, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
  .err_threshold, .samples_less_one, .lane0_check_value, .lane_align_mask,
  .disparity_threshold_flags, .disparity_counter_off);

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic mclk, sys_rst, reg_wr_en, reg_rd_en, samples_less_one, high_density_select;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, err_threshold, lane_align_mask;
  logic [3:0] disparity_err, invalid_symbol_err, stray_control_err;
  logic [3:0] disparity_threshold_flags, disparity_counter_off;
  logic [2:0] subclass_version, link_standard_version;
  logic [4:0] total_sample_bits_less_one, control_words_per_frame;
  logic [7:0] reserved_byte_one, reserved_byte_two, lane0_check_value;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  logic [11:0] ra [10] = '{12'h458, 12'h459, 12'h45A, 12'h45B, 12'h45C, 12'h45D,
    12'h46C, 12'h46D, 12'h46B, 12'h400};
  logic [7:0] rv [10] = '{8'h2F, 8'h20, 8'h80, 8'h00, 8'h00, 8'h45, 8'h0F, 8'h00,
    8'h00, 8'h00};
  slm_link_param_monitor #(.LANES(4)) u_dut (.mclk, .sys_rst, .reg_addr, .reg_wr_en,
    .reg_rd_en, .reg_wdata, .reg_rdata, .disparity_err, .invalid_symbol_err,
    .stray_control_err, .err_threshold, .subclass_version, .total_sample_bits_less_one,
    .link_standard_version, .samples_less_one, .high_density_select,
    .control_words_per_frame, .reserved_byte_one, .reserved_byte_two,
    .lane0_check_value, .lane_align_mask, .disparity_threshold_flags,
    .disparity_counter_off);
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    chk(lane_align_mask, 8'h0F);
    chk({subclass_version, total_sample_bits_less_one}, 8'h2F);
    chk({link_standard_version, 4'h0, samples_less_one}, 8'h20);
    chk({high_density_select, 2'h0, control_words_per_frame}, 8'h80);
    chk(lane0_check_value, 8'h45);
    chk(reserved_byte_one, 8'h00);
    chk(reserved_byte_two, 8'h00);
  endtask
  task automatic t_cfg;
    wr(12'h458, 8'h0F);
    rd(12'h458, 8'h0F);
    chk({subclass_version, total_sample_bits_less_one}, 8'h0F);
    wr(12'h45D, 8'hA5);
    rd(12'h45D, 8'hA5);
    chk(lane0_check_value, 8'hA5);
    wr(12'h459, 8'h3F);
    rd(12'h459, 8'h21);
    chk({7'h0, samples_less_one}, 8'h01);
    chk({5'h00, link_standard_version}, 8'h01);
    wr(12'h45A, 8'h00);
    chk({7'h0, high_density_select}, 8'h00);
    chk({3'h0, control_words_per_frame}, 8'h00);
    wr(12'h45B, 8'h5A);
    wr(12'h45C, 8'hC3);
    chk(reserved_byte_one, 8'h5A);
    chk(reserved_byte_two, 8'hC3);
    rd(12'h45B, 8'h5A);
    wr(12'h46C, 8'h05);
    chk(lane_align_mask, 8'h05);
  endtask
  task automatic t_mon;
    logic [7:0] e;
    @(posedge mclk);
    invalid_symbol_err <= 4'h2;
    stray_control_err <= 4'h4;
    disparity_err <= 4'h8;
    @(posedge mclk);
    disparity_err <= 4'h0;
    @(posedge mclk);
    stray_control_err <= 4'h0;
    @(posedge mclk);
    invalid_symbol_err <= 4'h0;
    for (int t = 0; t < 4; t++) begin
      for (int l = 0; l < 4; l++) begin
        e = (t == 0 && l == 3) ? 8'h01 : (t == 1 && l == 1) ? 8'h03 :
          (t == 2 && l == 2) ? 8'h02 : 8'h00;
        wr(12'h46B, {1'b0, l[2:0], 2'b00, t[1:0]});
        rd(12'h46B, e);
      end
    end
  endtask
  task automatic t_flag;
    @(posedge mclk);
    err_threshold <= 8'h02;
    disparity_err <= 4'h1;
    repeat (2) @(posedge mclk);
    disparity_err <= 4'h0;
    rd(12'h46D, 8'h01);
    repeat (5) @(posedge mclk);
    rd(12'h46D, 8'h01);
    @(posedge mclk);
    err_threshold <= 8'h05;
    wr(12'h46D, 8'h80);
    rd(12'h46D, 8'h00);
    @(posedge mclk);
    err_threshold <= 8'h02;
    rd(12'h46D, 8'h01);
    wr(12'h46D, 8'h20);
    rd(12'h46D, 8'h00);
    wr(12'h46B, 8'h00);
    rd(12'h46B, 8'h00);
    wr(12'h46D, 8'h40);
    chk({4'h0, disparity_counter_off}, 8'h01);
    @(posedge mclk);
    disparity_err <= 4'h1;
    repeat (3) @(posedge mclk);
    disparity_err <= 4'h0;
    rd(12'h46B, 8'h00);
  endtask
  task automatic t_rst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({4'h0, disparity_counter_off}, 8'h00);
    chk(lane_align_mask, 8'h0F);
    chk(lane0_check_value, 8'h45);
    rd(12'h45D, 8'h45);
  endtask
  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Whole run needs well under 1000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    err_threshold = 8'h00;
    disparity_err = 4'h0;
    invalid_symbol_err = 4'h0;
    stray_control_err = 4'h0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_cfg;
    t_mon;
    t_flag;
    t_rst;
    conclude;
  end
endmodule

// ===== rtl/slm_link_param_monitor.sv
`timescale 1ns/10ps
module slm_link_param_monitor #(
  parameter int LANES = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [LANES-1:0] disparity_err,
  input wire logic [LANES-1:0] invalid_symbol_err,
  input wire logic [LANES-1:0] stray_control_err,
  input wire logic [7:0] err_threshold,
  output logic [2:0] subclass_version,
  output logic [4:0] total_sample_bits_less_one,
  output logic [2:0] link_standard_version,
  output logic samples_less_one,
  output logic high_density_select,
  output logic [4:0] control_words_per_frame,
  output logic [7:0] reserved_byte_one,
  output logic [7:0] reserved_byte_two,
  output logic [7:0] lane0_check_value,
  output logic [7:0] lane_align_mask,
  output logic [LANES-1:0] disparity_threshold_flags,
  output logic [LANES-1:0] disparity_counter_off
);

  // ==========================================================
  // Configuration registers
  logic [2:0] subclass_reg;
  logic [2:0] subclass_next;
  logic [4:0] sbits_reg;
  logic [4:0] sbits_next;
  logic [2:0] version_reg;
  logic [2:0] version_next;
  logic samples_reg;
  logic samples_next;
  logic dense_reg;
  logic dense_next;
  logic [1:0] dens_rsvd_reg;
  logic [1:0] dens_rsvd_next;
  logic [4:0] ctlw_reg;
  logic [4:0] ctlw_next;
  logic [7:0] rsv_one_reg;
  logic [7:0] rsv_one_next;
  logic [7:0] rsv_two_reg;
  logic [7:0] rsv_two_next;
  logic [7:0] chk_reg;
  logic [7:0] chk_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [2:0] lane_pick_reg;
  logic [2:0] lane_pick_next;
  logic [1:0] cntr_pick_reg;
  logic [1:0] cntr_pick_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Lane fields are 3 bits, so only lane numbers 0 to 7 can be picked
  logic [LANES*8-1:0] disp_cnt_flat;
  logic [LANES*8-1:0] nit_cnt_flat;
  logic [LANES*8-1:0] ucc_cnt_flat;
  logic [LANES-1:0] flag_flat;
  logic [LANES-1:0] off_flat;

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] pick_byte(input logic [LANES*8-1:0] v,
                                           input logic [2:0] lane);
    pick_byte = 8'h00;
    for (int i = 0; i < LANES; i++) begin
      if (lane == i[2:0]) begin
        pick_byte = v[i*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // Write path
  logic cfg_wr;
  assign cfg_wr = reg_wr_en;

  always_comb begin
    subclass_next = subclass_reg;
    sbits_next = sbits_reg;
    version_next = version_reg;
    samples_next = samples_reg;
    dense_next = dense_reg;
    dens_rsvd_next = dens_rsvd_reg;
    ctlw_next = ctlw_reg;
    rsv_one_next = rsv_one_reg;
    rsv_two_next = rsv_two_reg;
    chk_next = chk_reg;
    mask_next = mask_reg;
    lane_pick_next = lane_pick_reg;
    cntr_pick_next = cntr_pick_reg;
    if (cfg_wr) begin
      if (hit(reg_addr, slm_pkg::SLM_OFS_SAMPLE_BITS)) begin
        subclass_next = reg_wdata[7:5];
        sbits_next = reg_wdata[4:0]; // see R01
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_VERSION_SAMPLES)) begin
        version_next = reg_wdata[7:5];
        samples_next = reg_wdata[0]; // see R02
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_DENSITY_CTRL)) begin
        dense_next = reg_wdata[slm_pkg::SLM_DENSITY_BIT]; // see R03
        dens_rsvd_next = reg_wdata[6:5];
        ctlw_next = reg_wdata[4:0]; // see R04
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_RESERVED_ONE)) begin
        rsv_one_next = reg_wdata;
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_RESERVED_TWO)) begin
        rsv_two_next = reg_wdata;
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_CHECKSUM)) begin
        chk_next = reg_wdata; // see R05
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_DESKEW_MASK)) begin
        mask_next = reg_wdata; // see R09
      end
      if (hit(reg_addr, slm_pkg::SLM_OFS_ERR_MONITOR)) begin
        lane_pick_next = reg_wdata[6:4]; // see R08
        cntr_pick_next = reg_wdata[1:0]; // see R06
      end
    end
  end

  // ==========================================================
  // Read path
  // Registered, so read data shows one cycle after the strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_en) begin
      rdata_next = 8'h00;
      unique case (1'b1)
        hit(reg_addr, slm_pkg::SLM_OFS_SAMPLE_BITS): rdata_next = {subclass_reg, sbits_reg};
        hit(reg_addr, slm_pkg::SLM_OFS_VERSION_SAMPLES): rdata_next = {version_reg, 4'h0,
                                                                       samples_reg};
        hit(reg_addr, slm_pkg::SLM_OFS_DENSITY_CTRL): rdata_next = {dense_reg, dens_rsvd_reg,
                                                                    ctlw_reg};
        hit(reg_addr, slm_pkg::SLM_OFS_RESERVED_ONE): rdata_next = rsv_one_reg;
        hit(reg_addr, slm_pkg::SLM_OFS_RESERVED_TWO): rdata_next = rsv_two_reg;
        hit(reg_addr, slm_pkg::SLM_OFS_CHECKSUM): rdata_next = chk_reg;
        hit(reg_addr, slm_pkg::SLM_OFS_DESKEW_MASK): rdata_next = mask_reg;
        hit(reg_addr, slm_pkg::SLM_OFS_DISPARITY): begin
          rdata_next = 8'h00;
          rdata_next[LANES-1:0] = flag_flat; // see R10
        end
        hit(reg_addr, slm_pkg::SLM_OFS_ERR_MONITOR): begin
          // Pick 11 and absent lanes read zero
          unique case (cntr_pick_reg) // see R07
            slm_pkg::SLM_CNT_DISPARITY: rdata_next = pick_byte(disp_cnt_flat, lane_pick_reg);
            slm_pkg::SLM_CNT_INVALID: rdata_next = pick_byte(nit_cnt_flat, lane_pick_reg);
            slm_pkg::SLM_CNT_STRAY: rdata_next = pick_byte(ucc_cnt_flat, lane_pick_reg);
            default: rdata_next = 8'h00;
          endcase
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Register stage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      subclass_reg <= slm_pkg::SLM_RST_SUBCLASS;
      sbits_reg <= slm_pkg::SLM_RST_SAMPLE_BITS;
      version_reg <= slm_pkg::SLM_RST_VERSION;
      samples_reg <= slm_pkg::SLM_RST_SAMPLES;
      dense_reg <= slm_pkg::SLM_RST_HIGH_DENSITY;
      dens_rsvd_reg <= slm_pkg::SLM_RST_DENS_RSVD;
      ctlw_reg <= slm_pkg::SLM_RST_CTRL_WORDS;
      rsv_one_reg <= slm_pkg::SLM_RST_RESERVED;
      rsv_two_reg <= slm_pkg::SLM_RST_RESERVED;
      chk_reg <= slm_pkg::SLM_RST_CHECKSUM;
      mask_reg <= slm_pkg::SLM_RST_DESKEW;
      lane_pick_reg <= slm_pkg::SLM_RST_LANE_PICK;
      cntr_pick_reg <= slm_pkg::SLM_RST_CNTR_PICK;
      rdata_reg <= 8'h00;
    end else begin
      subclass_reg <= subclass_next;
      sbits_reg <= sbits_next;
      version_reg <= version_next;
      samples_reg <= samples_next;
      dense_reg <= dense_next;
      dens_rsvd_reg <= dens_rsvd_next;
      ctlw_reg <= ctlw_next;
      rsv_one_reg <= rsv_one_next;
      rsv_two_reg <= rsv_two_next;
      chk_reg <= chk_next;
      mask_reg <= mask_next;
      lane_pick_reg <= lane_pick_next;
      cntr_pick_reg <= cntr_pick_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Per-lane error counters and flags
  logic ctl_wr;
  assign ctl_wr = reg_wr_en && hit(reg_addr, slm_pkg::SLM_OFS_DISPARITY);

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] disp_reg;
    logic [7:0] disp_next;
    logic [7:0] nit_reg;
    logic [7:0] nit_next;
    logic [7:0] ucc_reg;
    logic [7:0] ucc_next;
    logic flag_reg;
    logic flag_next;
    logic off_reg;
    logic off_next;
    logic mine;
    logic off_wr;
    logic cnt_clr_wr;
    logic irq_clr_wr;
    assign mine = ctl_wr && (reg_wdata[2:0] == 3'(g));
    assign off_wr = mine && reg_wdata[slm_pkg::SLM_CNT_OFF_BIT];
    assign cnt_clr_wr = mine && reg_wdata[slm_pkg::SLM_CNT_CLR_BIT];
    assign irq_clr_wr = mine && reg_wdata[slm_pkg::SLM_IRQ_CLR_BIT];

    always_comb begin
      disp_next = disp_reg;
      nit_next = nit_reg;
      ucc_next = ucc_reg;
      off_next = off_reg;
      flag_next = flag_reg;
      // Only sys_rst turns a disabled counter back on
      if (off_wr) begin
        off_next = 1'b1; // see R12
      end
      // Counters saturate so a long burst cannot wrap under the threshold
      if (disparity_err[g] && !off_reg && disp_reg != slm_pkg::SLM_COUNT_MAX) begin
        disp_next = disp_reg + 8'h01;
      end
      if (cnt_clr_wr) begin
        disp_next = slm_pkg::SLM_RST_COUNT; // see R12
      end
      // No clear path for these two, only sys_rst zeroes them
      if (invalid_symbol_err[g] && nit_reg != slm_pkg::SLM_COUNT_MAX) begin
        nit_next = nit_reg + 8'h01;
      end
      if (stray_control_err[g] && ucc_reg != slm_pkg::SLM_COUNT_MAX) begin
        ucc_next = ucc_reg + 8'h01;
      end
      if (irq_clr_wr || cnt_clr_wr) begin
        flag_next = 1'b0; // see R11, see R13
      end
      // Set beats an interrupt clear when the count still stands at threshold; a counter reset wins over set
      if (err_threshold != 8'h00 && disp_reg >= err_threshold && !cnt_clr_wr) begin
        flag_next = 1'b1; // see R10, see R13
      end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        disp_reg <= slm_pkg::SLM_RST_COUNT;
        nit_reg <= slm_pkg::SLM_RST_COUNT;
        ucc_reg <= slm_pkg::SLM_RST_COUNT;
        flag_reg <= 1'b0;
        off_reg <= 1'b0;
      end else begin
        disp_reg <= disp_next;
        nit_reg <= nit_next;
        ucc_reg <= ucc_next;
        flag_reg <= flag_next;
        off_reg <= off_next;
      end
    end

    assign disp_cnt_flat[g*8 +: 8] = disp_reg;
    assign nit_cnt_flat[g*8 +: 8] = nit_reg;
    assign ucc_cnt_flat[g*8 +: 8] = ucc_reg;
    assign flag_flat[g] = flag_reg;
    assign off_flat[g] = off_reg;
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign reg_rdata = rdata_reg;
  assign subclass_version = subclass_reg;
  assign total_sample_bits_less_one = sbits_reg;
  assign link_standard_version = version_reg;
  assign samples_less_one = samples_reg;
  assign high_density_select = dense_reg;
  assign control_words_per_frame = ctlw_reg;
  assign reserved_byte_one = rsv_one_reg;
  assign reserved_byte_two = rsv_two_reg;
  assign lane0_check_value = chk_reg;
  assign lane_align_mask = mask_reg; // see R09
  assign disparity_threshold_flags = flag_flat;
  assign disparity_counter_off = off_flat;

endmodule

// ===== rtl/slm_pkg.sv
// Behaviour
// R01 - Software must write 0xF into the bits-per-sample field [4:0], meaning 16 bits per sample.
// R02 - The samples-per-frame field resets to 0 and holds only 0 (one sample) or 1 (two samples).
// R03 - The high-density bit 7 resets to 1; software writes 1 for one octet per frame, else 0.
// R04 - Software keeps the control-words-per-frame field at 0.
// R05 - The lane 0 checksum is an 8-bit read/write register that resets to 0x45.
// R06 - A write to the monitor address stores lane and counter picks; a read returns that count.
// R07 - Counter pick 00 gives bad disparity, 01 not-in-table, 10 stray control character.
// R08 - The lane pick in bits [6:4] chooses the lane; both picks are write-only and reset to 0.
// R09 - Lane x is deskewed while bit x of the deskew mask is set; the mask resets to 0xF.
// R10 - Flag bit x sets when the bad-disparity count of lane x reaches the threshold.
// R11 - Writing 1 to bit 7 of the disparity control clears the flag of the lane in bits [2:0]; the flag stays set while the count meets a nonzero threshold.
// R12 - Writing 1 to bit 6 disables and to bit 5 resets the disparity counter of that lane.
// R13 - A disparity flag stays set until an interrupt clear or a counter reset for its lane; interrupt clears fail while the count meets a nonzero threshold.
package slm_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] SLM_OFS_SAMPLE_BITS = 12'h458;
  localparam logic [11:0] SLM_OFS_VERSION_SAMPLES = 12'h459;
  localparam logic [11:0] SLM_OFS_DENSITY_CTRL = 12'h45A;
  localparam logic [11:0] SLM_OFS_RESERVED_ONE = 12'h45B;
  localparam logic [11:0] SLM_OFS_RESERVED_TWO = 12'h45C;
  localparam logic [11:0] SLM_OFS_CHECKSUM = 12'h45D;
  localparam logic [11:0] SLM_OFS_ERR_MONITOR = 12'h46B;
  localparam logic [11:0] SLM_OFS_DESKEW_MASK = 12'h46C;
  localparam logic [11:0] SLM_OFS_DISPARITY = 12'h46D;

  // ==========================================================
  // Reset values
  localparam logic [2:0] SLM_RST_SUBCLASS = 3'h1;
  localparam logic [4:0] SLM_RST_SAMPLE_BITS = 5'h0F;
  localparam logic [2:0] SLM_RST_VERSION = 3'h1;
  localparam logic SLM_RST_SAMPLES = 1'h0;
  localparam logic SLM_RST_HIGH_DENSITY = 1'h1;
  localparam logic [1:0] SLM_RST_DENS_RSVD = 2'h0;
  localparam logic [4:0] SLM_RST_CTRL_WORDS = 5'h00;
  localparam logic [7:0] SLM_RST_RESERVED = 8'h00;
  localparam logic [7:0] SLM_RST_CHECKSUM = 8'h45;
  localparam logic [7:0] SLM_RST_DESKEW = 8'h0F;
  localparam logic [2:0] SLM_RST_LANE_PICK = 3'h0;
  localparam logic [1:0] SLM_RST_CNTR_PICK = 2'h0;
  localparam logic [7:0] SLM_RST_COUNT = 8'h00;
  localparam logic [7:0] SLM_COUNT_MAX = 8'hFF;

  // ==========================================================
  // Field positions
  localparam int SLM_DENSITY_BIT = 7;
  localparam int SLM_IRQ_CLR_BIT = 7;
  localparam int SLM_CNT_OFF_BIT = 6;
  localparam int SLM_CNT_CLR_BIT = 5;

  // ==========================================================
  // Counter pick encodings
  typedef enum logic [1:0] {
    SLM_CNT_DISPARITY = 2'h0,
    SLM_CNT_INVALID = 2'h1,
    SLM_CNT_STRAY = 2'h2
  } slm_cnt_pick_t;

endpackage
